// ### rtl/sep_pkg.sv
/*
  Shared constants for the three-wire serial EEPROM command port.
  Assumes a 200 MHz system clock and an external word array behind a request buffer.
*/
`default_nettype none
package sep_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int NS_PER_MS = 1000000;
  // Program cycle limits, longest times, rounded down to cycles
  localparam int T_WC_LV_SMALL_MS = 6;
  localparam int T_WC_LV_LARGE_MS = 5;
  localparam int T_WC_HV_MS = 2;
  localparam int ERASE_ALL_TIME_MS = 6;
  localparam int WRITE_ALL_TIME_MS = 15;
  localparam int WC_LV_SMALL_CYC = T_WC_LV_SMALL_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int WC_LV_LARGE_CYC = T_WC_LV_LARGE_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int WC_HV_CYC = T_WC_HV_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int ERASE_ALL_CYC = ERASE_ALL_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int WRITE_ALL_CYC = WRITE_ALL_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int TIMER_W = 22;
  // Word and address geometry
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 11;
  localparam int CNT_W = 6;
  localparam int OPC_W = 2;
  localparam int AW_1K = 6;
  localparam int AW_2K_4K = 8;
  localparam int AW_8K_16K = 10;
  localparam int DENS_1K = 1;
  localparam int DENS_2K = 2;
  localparam int DENS_4K = 4;
  localparam int DENS_8K = 8;
  // Opcodes and extended codes
  localparam logic [1:0] OPC_READ = 2'h2;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  localparam logic [1:0] OPC_EXT = 2'h0;
  localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
  localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
  localparam logic [1:0] EXT_UNLOCK = 2'h3;
  localparam logic [1:0] EXT_LOCK = 2'h0;
  typedef enum logic [2:0] {SEP_OP_READ, SEP_OP_WRITE, SEP_OP_ERASE, SEP_OP_ERASE_ALL, SEP_OP_WRITE_ALL} sep_op_e;
  localparam int REQ_W = 3 + ADDR_W + WORD_W;
  typedef enum logic [1:0] {SEP_IDLE, SEP_SHIFT, SEP_HELD, SEP_READ} sep_state_e;
endpackage : sep_pkg
`default_nettype wire

// ### rtl/sep_fifo2.sv
/*
  Two-entry request buffer with valid/ready on both sides.
  Assumes a single clock domain; output side is registered.
*/
`default_nettype none
module sep_fifo2 #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  logic [WIDTH-1:0] mem_q [2];
  logic [WIDTH-1:0] mem_d [2];
  logic [1:0] cnt_q, cnt_d;
  logic vld_q, vld_d;

  assign in_ready_o = (cnt_q != 2'h2);
  // Valid kept in its own flop so the output leaves a register
  assign out_valid_o = vld_q;
  assign out_data_o = mem_q[0];

  always_comb begin
    mem_d = mem_q;
    cnt_d = cnt_q;
    if (out_valid_o && out_ready_i) begin
      mem_d[0] = mem_q[1];
      cnt_d = cnt_q - 2'h1;
    end
    if (in_valid_i && in_ready_o) begin
      mem_d[cnt_d[0]] = in_data_i;
      cnt_d = cnt_d + 2'h1;
    end
    vld_d = (cnt_d != 2'h0);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      cnt_q <= 2'h0;
      vld_q <= 1'b0;
    end else begin
      mem_q <= mem_d;
      cnt_q <= cnt_d;
      vld_q <= vld_d;
    end
  end
endmodule : sep_fifo2
`default_nettype wire

// ### rtl/sep_port.sv
/*
  Device-side command decoder and sequencer of a three-wire serial EEPROM.
  Assumes select, serial clock and serial_in come from another domain; the word array sits behind
  the request buffer and answers reads with a one-cycle rdata valid within a few system clocks.
*/
// How it works
// R1 - Start bit then two-bit opcode, address follows
// R2 - Opcode 00 extended by next two bits
// R3 - word_width_select high: 16-bit, low: 8-bit
// R4 - Address width per density, MSB first
// R5 - 2K/8K: first address position ignored
// R6 - Read shifts addressed word out MSB first
// R7 - Host sends full required clock count
// R8 - Host sends full data word for writes
// R9 - Programming commands report ready_busy_flag
// R10 - Unlock/lock leave serial_out high-impedance
// R11 - Low-voltage word cycle 6 or 5 ms
// R12 - Five-volt word cycle within 2 ms
// R13 - Erase_all cycle within 6 ms
// R14 - Write_all cycle within 15 ms
// R15 - Host clears status before standby
// R16 - Fixed variants ignore width and permit pins
// R17 - Start on first rise with select, serial_in high
// R18 - Capture serial_in on serial clock rise
// R19 - Power-up locked; unlock needed to program
// R20 - Status poll: low busy, high ready
// R21 - Short instruction at select fall discarded
// R22 - Internal counter times program cycle
`default_nettype none
module sep_port
  import sep_pkg::*;
#(
  parameter int DENSITY_KBIT = 16,
  parameter bit LOW_VOLTAGE = 1'b1,
  parameter bit SELECTABLE = 1'b1,
  parameter bit FIXED_X16 = 1'b0,
  parameter int WORD_CYC = LOW_VOLTAGE ? ((DENSITY_KBIT <= DENS_4K) ? WC_LV_SMALL_CYC : WC_LV_LARGE_CYC) : WC_HV_CYC,
  parameter int ERASE_ALL_CYCLES = ERASE_ALL_CYC,
  parameter int WRITE_ALL_CYCLES = WRITE_ALL_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic select_i,
  input wire logic sclk_i,
  input wire logic serial_in_i,
  input wire logic word_width_select_i,
  input wire logic program_permit_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  output logic mem_req_valid_o,
  input wire logic mem_req_ready_i,
  output logic [2:0] mem_req_kind_o,
  output logic [ADDR_W-1:0] mem_req_addr_o,
  output logic [WORD_W-1:0] mem_req_data_o,
  input wire logic mem_rdata_valid_i,
  input wire logic [WORD_W-1:0] mem_rdata_i
);
  localparam int AW_BASE = (DENSITY_KBIT == DENS_1K) ? AW_1K : (DENSITY_KBIT <= DENS_4K) ? AW_2K_4K : AW_8K_16K;
  localparam bit DROP_TOP = (DENSITY_KBIT == DENS_2K) || (DENSITY_KBIT == DENS_8K);
  localparam bit PERMIT_PIN = SELECTABLE && (DENSITY_KBIT >= DENS_8K);

  logic [1:0] sel_s, din_s, wws_s, pp_s;
  logic [2:0] clk_s;
  logic sel_q;
  sep_state_e st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [WORD_W-1:0] sr_q, sr_d, rdat_q, rdat_d;
  logic [OPC_W-1:0] op_q, op_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [4:0] obit_q, obit_d;
  logic unlock_q, unlock_d, busy_q, busy_d, stat_q, stat_d;
  logic [TIMER_W-1:0] timer_q, timer_d;
  logic pend_q, pend_d;
  logic [REQ_W-1:0] preq_q, preq_d;
  logic so_q, so_d, soe_q, soe_d;
  logic rise, sel_fall, x16, fifo_rdy, nd;
  logic [CNT_W-1:0] aw, n_addr, cnt_n, wbits;
  logic [ADDR_W-1:0] raw, mask, amask;
  logic [1:0] ext;
  logic [REQ_W-1:0] fifo_out;

  // R18 - serial clock rising edge
  assign rise = clk_s[1] & ~clk_s[2];
  assign sel_fall = sel_q & ~sel_s[1];
  // R16 - fixed variants ignore pin
  // R3 - word width selection
  assign x16 = SELECTABLE ? wws_s[1] : FIXED_X16;
  // R4 - address width per density
  assign aw = CNT_W'(AW_BASE) + (x16 ? CNT_W'(0) : CNT_W'(1));
  // R7 - required clock count
  assign n_addr = aw + CNT_W'(OPC_W);
  assign wbits = x16 ? CNT_W'(WORD_W) : CNT_W'(BYTE_W);
  assign cnt_n = cnt_q + CNT_W'(1);
  assign raw = ADDR_W'({sr_q[ADDR_W-2:0], din_s[1]});
  assign mask = ~(ADDR_W'('1) << aw);
  // R5 - drop first address position
  assign amask = DROP_TOP ? (mask >> 1) : mask;
  // R2 - extended opcode bits
  assign ext = 2'(addr_q >> (aw - CNT_W'(2)));
  assign nd = (op_q == OPC_WRITE) || (op_q == OPC_EXT && ext == EXT_WRITE_ALL);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sr_d = sr_q;
    op_d = op_q;
    addr_d = addr_q;
    rdat_d = rdat_q;
    obit_d = obit_q;
    unlock_d = unlock_q;
    busy_d = busy_q;
    stat_d = stat_q;
    timer_d = timer_q;
    pend_d = pend_q && !fifo_rdy;
    preq_d = preq_q;
    so_d = so_q;
    soe_d = 1'b0;
    // R22 - internal program timer
    if (busy_q) begin
      timer_d = timer_q - TIMER_W'(1);
      if (timer_q == TIMER_W'(1)) begin
        busy_d = 1'b0;
      end
    end
    if (mem_rdata_valid_i) begin
      rdat_d = x16 ? mem_rdata_i : {mem_rdata_i[BYTE_W-1:0], 8'h00};
    end
    case (st_q)
      SEP_IDLE: begin
        // R17 - start bit detection
        if (rise && sel_s[1] && din_s[1] && !busy_q) begin
          st_d = SEP_SHIFT;
          cnt_d = '0;
          // R15 - start clears status
          stat_d = 1'b0;
        end
      end
      SEP_SHIFT: begin
        if (rise) begin
          // R1 - opcode then address
          sr_d = {sr_q[WORD_W-2:0], din_s[1]};
          cnt_d = cnt_n;
          if (cnt_n == CNT_W'(OPC_W)) begin
            op_d = sr_d[1:0];
          end else if (cnt_n == n_addr) begin
            addr_d = raw;
            if (op_q == OPC_READ) begin
              // R6 - dummy zero then data
              st_d = SEP_READ;
              obit_d = '0;
              so_d = 1'b0;
              pend_d = 1'b1;
              preq_d = {SEP_OP_READ, raw & amask, 16'h0000};
            end else if (!((op_q == OPC_WRITE) || (op_q == OPC_EXT && 2'(raw >> (aw - CNT_W'(2))) == EXT_WRITE_ALL))) begin
              st_d = SEP_HELD;
            end
          // R8 - full data word collected
          end else if (cnt_q > n_addr && cnt_n == n_addr + wbits && nd) begin
            st_d = SEP_HELD;
          end
        end
      end
      SEP_READ: begin
        if (rise) begin
          so_d = rdat_q[WORD_W-1];
          rdat_d = {rdat_q[WORD_W-2:0], 1'b0};
          obit_d = obit_q + 5'h01;
          if (obit_q == 5'(wbits - CNT_W'(1))) begin
            obit_d = '0;
            addr_d = (addr_q + ADDR_W'(1)) & amask;
            pend_d = 1'b1;
            preq_d = {SEP_OP_READ, (addr_q + ADDR_W'(1)) & amask, 16'h0000};
          end
        end
      end
      default: begin
      end
    endcase
    if (st_q == SEP_READ) begin
      soe_d = sel_s[1];
    end else if (stat_q && sel_s[1]) begin
      // R20 - ready high, busy low
      soe_d = 1'b1;
      so_d = !busy_d;
    end
    if (sel_fall) begin
      // R21 - incomplete instruction discarded
      st_d = SEP_IDLE;
      soe_d = 1'b0;
      if (st_q == SEP_HELD) begin
        if (op_q == OPC_EXT && ext == EXT_UNLOCK) begin
          // R10 - no status for unlock
          // R19 - unlock enables programming
          unlock_d = 1'b1;
        end else if (op_q == OPC_EXT && ext == EXT_LOCK) begin
          unlock_d = 1'b0;
        end else if (unlock_q && (!PERMIT_PIN || pp_s[1])) begin
          // R9 - status follows programming
          stat_d = 1'b1;
          busy_d = 1'b1;
          pend_d = 1'b1;
          if (op_q == OPC_EXT && ext == EXT_ERASE_ALL) begin
            // R13 - erase_all time
            timer_d = TIMER_W'(ERASE_ALL_CYCLES);
            preq_d = {SEP_OP_ERASE_ALL, 11'h000, 16'hFFFF};
          end else if (op_q == OPC_EXT) begin
            // R14 - write_all time
            timer_d = TIMER_W'(WRITE_ALL_CYCLES);
            preq_d = {SEP_OP_WRITE_ALL, 11'h000, x16 ? sr_q : {8'h00, sr_q[BYTE_W-1:0]}};
          end else begin
            // R11 - word cycle time
            // R12 - five-volt word time
            timer_d = TIMER_W'(WORD_CYC);
            preq_d = {(op_q == OPC_ERASE) ? SEP_OP_ERASE : SEP_OP_WRITE, addr_q & amask,
                      (op_q == OPC_ERASE) ? 16'hFFFF : (x16 ? sr_q : {8'h00, sr_q[BYTE_W-1:0]})};
          end
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_s <= 2'h0;
      clk_s <= 3'h0;
      din_s <= 2'h0;
      wws_s <= 2'h0;
      pp_s <= 2'h0;
      sel_q <= 1'b0;
      st_q <= SEP_IDLE;
      cnt_q <= '0;
      sr_q <= '0;
      op_q <= '0;
      addr_q <= '0;
      rdat_q <= '0;
      obit_q <= '0;
      unlock_q <= 1'b0;
      busy_q <= 1'b0;
      stat_q <= 1'b0;
      timer_q <= '0;
      pend_q <= 1'b0;
      preq_q <= '0;
      so_q <= 1'b0;
      soe_q <= 1'b0;
    end else begin
      sel_s <= {sel_s[0], select_i};
      clk_s <= {clk_s[1:0], sclk_i};
      din_s <= {din_s[0], serial_in_i};
      wws_s <= {wws_s[0], word_width_select_i};
      pp_s <= {pp_s[0], program_permit_i};
      sel_q <= sel_s[1];
      st_q <= st_d;
      cnt_q <= cnt_d;
      sr_q <= sr_d;
      op_q <= op_d;
      addr_q <= addr_d;
      rdat_q <= rdat_d;
      obit_q <= obit_d;
      unlock_q <= unlock_d;
      busy_q <= busy_d;
      stat_q <= stat_d;
      timer_q <= timer_d;
      pend_q <= pend_d;
      preq_q <= preq_d;
      so_q <= so_d;
      soe_q <= soe_d;
    end
  end

  assign serial_out_o = so_q;
  assign serial_out_oe_o = soe_q;

  sep_fifo2 #(
    .WIDTH(REQ_W)
  ) u_req_buf (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(pend_q),
    .in_data_i(preq_q),
    .in_ready_o(fifo_rdy),
    .out_valid_o(mem_req_valid_o),
    .out_data_o(fifo_out),
    .out_ready_i(mem_req_ready_i)
  );
  assign mem_req_kind_o = fifo_out[REQ_W-1 -: 3];
  assign mem_req_addr_o = fifo_out[WORD_W +: ADDR_W];
  assign mem_req_data_o = fifo_out[WORD_W-1:0];
endmodule : sep_port
`default_nettype wire

// ### dv/sep_mem_model.sv
/*
  Word array model behind the request buffer.
  Assumes one request taken per valid/ready edge; slow_i stalls every other cycle.
*/
`default_nettype none
module sep_mem_model (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [2:0] kind_i,
  input wire logic [10:0] addr_i,
  input wire logic [15:0] data_i,
  output logic rdata_valid_o,
  output logic [15:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:2047];
  logic tog_q;
  logic take;
  assign req_ready_o = !slow_i || tog_q;
  assign take = req_valid_i && req_ready_o;
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tog_q <= 1'b0;
      rdata_valid_o <= 1'b0;
      rdata_o <= 16'h0000;
      for (int i = 0; i < 2048; i++) begin
        mem[i] <= 16'(i) ^ 16'h5A5A;
      end
    end else begin
      tog_q <= !tog_q;
      rdata_valid_o <= take && kind_i == 3'h0;
      // Idle read lines toggle so a late capture is seen
      rdata_o <= (take && kind_i == 3'h0) ? mem[addr_i] : ~rdata_o;
      for (int i = 0; i < 2048; i++) begin
        if (take && kind_i != 3'h0 && (kind_i > 3'h2 || i == int'(addr_i))) begin
          mem[i] <= (kind_i == 3'h3) ? 16'hFFFF : data_i;
        end
      end
    end
  end
endmodule : sep_mem_model
`default_nettype wire

// ### dv/sep_port_asserts.sv
/*
  Port checker for the command port.
  Assumes it is bound onto every sep_port instance.
*/
`default_nettype none
module sep_port_asserts
  import sep_pkg::*;
#(
  parameter int DENSITY_KBIT = 16,
  parameter int WORD_CYC = 50
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic select_i,
  input wire logic sclk_i,
  input wire logic serial_in_i,
  input wire logic word_width_select_i,
  input wire logic program_permit_i,
  input wire logic serial_out_o,
  input wire logic serial_out_oe_o,
  input wire logic mem_req_valid_o,
  input wire logic mem_req_ready_i,
  input wire logic [2:0] mem_req_kind_o,
  input wire logic [ADDR_W-1:0] mem_req_addr_o,
  input wire logic [WORD_W-1:0] mem_req_data_o,
  input wire logic mem_rdata_valid_i,
  input wire logic [WORD_W-1:0] mem_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [TIMER_W-1:0] low_q;
  logic [TIMER_W-1:0] low_d;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Length of one unbroken busy report
  always_comb begin
    low_d = (serial_out_oe_o && !serial_out_o) ? low_q + 1'b1 : '0;
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_q <= '0;
    end else begin
      low_q <= low_d;
    end
  end
  req_hold_a: assert property (mem_req_valid_o && !mem_req_ready_i |=> mem_req_valid_o &&
    $stable(mem_req_addr_o) && $stable(mem_req_data_o) && $stable(mem_req_kind_o)) else $error("request changed");
  out_release_a: assert property ($fell(select_i) |-> ##[1:6] !serial_out_oe_o)
    else $error("serial_out still driven");
  oe_sel_a: assert property ($rose(serial_out_oe_o) |-> select_i) else $error("drive without select");
  prog_late_a: assert property ($rose(mem_req_valid_o) && mem_req_kind_o != 3'h0 |-> !select_i)
    else $error("program before select fall");
  kind_legal_a: assert property (mem_req_valid_o |-> mem_req_kind_o <= 3'h4) else $error("bad kind");
  erase_ones_a: assert property (mem_req_valid_o && mem_req_kind_o == 3'h2 |-> mem_req_data_o == 16'hFFFF)
    else $error("erase data not ones");
  addr_range_a: assert property (mem_req_valid_o |-> int'(mem_req_addr_o) < DENSITY_KBIT * 128)
    else $error("address out of range");
  busy_len_a: assert property (low_q <= WORD_CYC + 20) else $error("busy too long");
  cover property (mem_req_valid_o && mem_req_ready_i && mem_req_kind_o == 3'h1);
  cover property (mem_req_valid_o && mem_req_ready_i && mem_req_kind_o == 3'h0);
  cover property (mem_req_valid_o && mem_req_ready_i && mem_req_kind_o == 3'h3);
endmodule : sep_port_asserts
bind sep_port sep_port_asserts #(.DENSITY_KBIT(DENSITY_KBIT), .WORD_CYC(WORD_CYC)) i_chk (.mclk_i(mclk_i),
  .rst_n_i(rst_n_i), .select_i(select_i), .sclk_i(sclk_i), .serial_in_i(serial_in_i),
  .word_width_select_i(word_width_select_i), .program_permit_i(program_permit_i), .serial_out_o(serial_out_o),
  .serial_out_oe_o(serial_out_oe_o), .mem_req_valid_o(mem_req_valid_o), .mem_req_ready_i(mem_req_ready_i),
  .mem_req_kind_o(mem_req_kind_o), .mem_req_addr_o(mem_req_addr_o), .mem_req_data_o(mem_req_data_o),
  .mem_rdata_valid_i(mem_rdata_valid_i), .mem_rdata_i(mem_rdata_i));
`default_nettype wire

// ### dv/test_sep_port.sv
/*
  Self-checking bench for the command port, 1 Kbit, short program timers.
  Assumes the array model and the bound checker.
*/
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; $display("ERROR %0t got %h", $time, a); end end
module test_sep_port
  import sep_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic select_i = 1'b0;
  logic sclk_i = 1'b0;
  logic serial_in_i = 1'b0;
  logic word_width_select_i = 1'b1;
  logic slow_i = 1'b0;
  logic serial_out_o, serial_out_oe_o, mem_req_valid_o, mem_req_ready_i, mem_rdata_valid_i;
  logic [2:0] mem_req_kind_o;
  logic [ADDR_W-1:0] mem_req_addr_o;
  logic [WORD_W-1:0] mem_req_data_o, mem_rdata_i;
  logic [31:0] rx;
  int err_total = 0;
  int n_tests = 0;
  always #2.5 mclk_i = ~mclk_i;
  sep_port #(.DENSITY_KBIT(1), .WORD_CYC(50), .ERASE_ALL_CYCLES(50), .WRITE_ALL_CYCLES(50)) i_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .select_i(select_i), .sclk_i(sclk_i), .serial_in_i(serial_in_i),
    .word_width_select_i(word_width_select_i), .program_permit_i(1'b1), .serial_out_o(serial_out_o),
    .serial_out_oe_o(serial_out_oe_o), .mem_req_valid_o(mem_req_valid_o), .mem_req_ready_i(mem_req_ready_i),
    .mem_req_kind_o(mem_req_kind_o), .mem_req_addr_o(mem_req_addr_o), .mem_req_data_o(mem_req_data_o),
    .mem_rdata_valid_i(mem_rdata_valid_i), .mem_rdata_i(mem_rdata_i));
  sep_mem_model i_mem (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .slow_i(slow_i), .req_valid_i(mem_req_valid_o),
    .req_ready_o(mem_req_ready_i), .kind_i(mem_req_kind_o), .addr_i(mem_req_addr_o), .data_i(mem_req_data_o),
    .rdata_valid_o(mem_rdata_valid_i), .rdata_o(mem_rdata_i));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  // one link clock, data set while low, output read late in high
  task automatic sbit(input logic b, output logic r);
    @(posedge mclk_i) #1 sclk_i = 1'b0;
    serial_in_i = b;
    repeat (6) @(posedge mclk_i);
    #1 sclk_i = 1'b1;
    repeat (6) @(posedge mclk_i);
    // Released line reads as the inverse
    #1 r = serial_out_oe_o ? serial_out_o : ~serial_out_o;
  endtask : sbit
  // n link clocks, then select fall
  task automatic cmd(input logic [31:0] v, input int n);
    @(posedge mclk_i) #1 select_i = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      sbit(v[i], rx[i]);
    end
    @(posedge mclk_i) #1 sclk_i = 1'b0;
    serial_in_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #1 select_i = 1'b0;
    repeat (8) @(posedge mclk_i);
  endtask : cmd
  task automatic poll();
    int i;
    @(posedge mclk_i) #1 select_i = 1'b1;
    repeat (6) @(posedge mclk_i);
    #1 `CHK(serial_out_oe_o, 1'b1)
    `CHK(serial_out_o, 1'b0)
    for (i = 0; i < 400 && serial_out_o !== 1'b1; i++) begin
      @(posedge mclk_i) #1;
    end
    if (i == 400) begin
      err_total++;
      $display("ERROR %0t busy never ended", $time);
      finish_test();
    end
    sbit(1'b1, rx[0]);
    `CHK(serial_out_oe_o, 1'b0)
    @(posedge mclk_i) #1 select_i = 1'b0;
    repeat (8) @(posedge mclk_i);
  endtask : poll
  task automatic quiet();
    @(posedge mclk_i) #1 select_i = 1'b1;
    repeat (6) @(posedge mclk_i);
    #1 `CHK(serial_out_oe_o, 1'b0)
    select_i = 1'b0;
    repeat (8) @(posedge mclk_i);
  endtask : quiet
  task automatic t_words();
    cmd({1'b1, OPC_WRITE, 6'h2A, 16'hA5C3}, 25);
    cmd({1'b1, OPC_READ, 6'h2A, 16'h0000}, 25);
    `CHK(rx[15:0], 16'h2A ^ 16'h5A5A)
    cmd({1'b1, OPC_EXT, EXT_UNLOCK, 4'h0}, 9);
    quiet();
    cmd({1'b1, OPC_WRITE, 6'h2A, 16'hA5C3}, 25);
    poll();
    cmd({1'b1, OPC_READ, 6'h2A, 16'h0000}, 25);
    `CHK(rx[16:0], {1'b0, 16'hA5C3})
    cmd({1'b1, OPC_WRITE, 6'h2B, 16'h1111} >> 5, 20);
    cmd({1'b1, OPC_READ, 6'h2B, 16'h0000}, 25);
    `CHK(rx[15:0], 16'h2B ^ 16'h5A5A)
    $display("test word write and read done");
  endtask : t_words
  task automatic t_bytes();
    @(posedge mclk_i) #1 word_width_select_i = 1'b0;
    cmd({1'b1, OPC_WRITE, 7'h55, 8'h96}, 18);
    poll();
    cmd({1'b1, OPC_READ, 7'h55, 8'h00}, 18);
    `CHK(rx[8:0], {1'b0, 8'h96})
    cmd({1'b1, OPC_ERASE, 7'h55}, 10);
    poll();
    cmd({1'b1, OPC_READ, 7'h55, 8'h00}, 18);
    `CHK(rx[7:0], 8'hFF)
    @(posedge mclk_i) #1 word_width_select_i = 1'b1;
    $display("test byte mode done");
  endtask : t_bytes
  task automatic t_all();
    @(posedge mclk_i) #1 slow_i = 1'b1;
    cmd({1'b1, OPC_EXT, EXT_WRITE_ALL, 4'h0, 16'h3C3C}, 25);
    poll();
    cmd({1'b1, OPC_READ, 6'h00, 16'h0000}, 25);
    `CHK(rx[15:0], 16'h3C3C)
    cmd({1'b1, OPC_EXT, EXT_ERASE_ALL, 4'h0}, 9);
    poll();
    cmd({1'b1, OPC_READ, 6'h3F, 16'h0000}, 25);
    `CHK(rx[15:0], 16'hFFFF)
    cmd({1'b1, OPC_EXT, EXT_LOCK, 4'h0}, 9);
    quiet();
    cmd({1'b1, OPC_WRITE, 6'h3F, 16'h1234}, 25);
    cmd({1'b1, OPC_READ, 6'h3F, 16'h0000}, 25);
    `CHK(rx[15:0], 16'hFFFF)
    $display("test whole array done");
  endtask : t_all
  initial begin
    repeat (12) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    repeat (4) @(posedge mclk_i);
    t_words();
    t_bytes();
    t_all();
    finish_test();
  end
  initial begin
    repeat (90000) @(posedge mclk_i);
    err_total++;
    finish_test();
  end
endmodule : test_sep_port
`default_nettype wire
